// File: kp_matrix_port.sv
`timescale 1ns/1ps

// How it works
// - Sixteen pins: up to eight rows by eight columns, spare pins as GPIO.
// - Direction zero means input; row pins then enable their pull-up.
// - Column output is totem-pole, or open-drain when its control bit set.
// - Row outputs are always totem-pole, no open-drain option.
// - Open-drain bit kills high drive; ignored while pin is an input.
// - Row enable includes that row in press detection and interrupts.
// - Reset clears control: rows disabled, columns totem-pole.
// - Row enable ignores direction; driving an enabled row low raises press.
// - Press flag sets when any enabled row is low after filtering; sticky.
// - Clearing press chain with key held gives a fresh press after delay.
// - Release flag sets when all enabled rows high after filtering; sticky.
// - Release flag normally sets again only after press then release.
// - Release interrupt enable gates the release flag onto the request.
// - Press interrupt enable gates the press flag onto the request.
// - Writing one to release-sync-set fills release chain; reads zero.
// - Writing one to press-sync-clear empties press chain; reads zero.
// - Release flag clears only on a written one; zero leaves it.
// - Flags may reassert; short events may pass an uninitialised chain.
// - Control and status take byte and halfword writes.
// - Press flag clears only on a written one.
// - Four-stage filter sampled at 256 Hz rejects noise shorter than three sample periods.
// - Data latch drives outputs; reads show pins for inputs; no reset.
// - Reset clears direction, all sixteen pins inputs.
module kp_matrix_port #(
  parameter int unsigned SAMPLE_DIV = kp_pkg::KP_SAMPLE_DIV,
  parameter int unsigned STAGES = kp_pkg::KP_SYNC_STAGES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port pins, split into input, output and enable
  input wire logic [15:0] pin_in,
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe,
  output logic [7:0] row_pullup_en,
  // Combined keypad request
  output logic kp_irq
);

  localparam int unsigned CW = (SAMPLE_DIV > 1) ? $clog2(SAMPLE_DIV) : 1;
  localparam logic [CW-1:0] CNT_LAST = CW'(SAMPLE_DIV - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic [15:0] ctrl_ff;
  logic [15:0] dir_ff;
  logic [15:0] data_ff;
  logic press_flag_ff;
  logic release_flag_ff;
  logic press_ie_ff;
  logic release_ie_ff;
  logic [31:0] prdata_ff;
  logic [STAGES-1:0] press_ch_ff;
  logic [STAGES-1:0] rel_ch_ff;
  logic [CW-1:0] cnt_ff;

  logic sel_ctrl;
  logic sel_stat;
  logic sel_dir;
  logic sel_data;
  logic hit;
  logic wr;
  logic stat_wr;
  logic press_clr;
  logic rel_clr;
  logic press_sync_clr;
  logic rel_sync_set;

  assign sel_ctrl = paddr == {kp_pkg::KP_CTRL_IDX[29:0], 2'b00};
  assign sel_stat = paddr == {kp_pkg::KP_STAT_IDX[29:0], 2'b00};
  assign sel_dir = paddr == {kp_pkg::KP_DIR_IDX[29:0], 2'b00};
  assign sel_data = paddr == {kp_pkg::KP_DATA_IDX[29:0], 2'b00};
  assign hit = sel_ctrl | sel_stat | sel_dir | sel_data;

  // Zero wait states; unmapped addresses answer with an error
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~hit;
  assign wr = psel & penable & pwrite & hit;
  assign stat_wr = wr & sel_stat;

  // Flag clears and chain commands live in the low status byte
  assign press_clr = stat_wr & pstrb[0] & pwdata[kp_pkg::KP_ST_PRESS];
  assign rel_clr = stat_wr & pstrb[0] & pwdata[kp_pkg::KP_ST_RELEASE];
  assign press_sync_clr =
    stat_wr & pstrb[0] & pwdata[kp_pkg::KP_ST_PRESS_CLR];
  assign rel_sync_set =
    stat_wr & pstrb[0] & pwdata[kp_pkg::KP_ST_REL_SET];

  // Byte-lane merge so byte and halfword writes touch only their lanes
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] wd,
                                        input logic [1:0] be);
    logic [15:0] r;
    r = old;
    if (be[0])
    begin
      r[7:0] = wd[7:0];
    end
    if (be[1])
    begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Control, direction and data registers

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_ff <= kp_pkg::KP_CTRL_RST;
    end
    else if (wr & sel_ctrl)
    begin
      ctrl_ff <= merge(ctrl_ff, pwdata[15:0], pstrb[1:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dir_ff <= kp_pkg::KP_DIR_RST;
    end
    else if (wr & sel_dir)
    begin
      dir_ff <= merge(dir_ff, pwdata[15:0], pstrb[1:0]);
    end
  end

  // Output latch deliberately has no reset; software loads it first
  always_ff @(posedge pclk)
  begin
    if (wr & sel_data)
    begin
      data_ff <= merge(data_ff, pwdata[15:0], pstrb[1:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      press_ie_ff <= 1'b0;
      release_ie_ff <= 1'b0;
    end
    else if (stat_wr & pstrb[1])
    begin
      press_ie_ff <= pwdata[kp_pkg::KP_ST_PRESS_IE];
      release_ie_ff <= pwdata[kp_pkg::KP_ST_REL_IE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins

  logic [15:0] sensed;
  logic [7:0] rows_en;
  logic [7:0] col_od;

  // Output pins read back their latch, inputs read the pin
  assign sensed = (dir_ff & data_ff) | (~dir_ff & pin_in);
  assign rows_en = ctrl_ff[7:0];
  assign col_od = ctrl_ff[15:8];

  // Masked by direction so the unreset latch never reaches the pins
  assign pin_out = data_ff & dir_ff;
  assign pin_oe[7:0] = dir_ff[7:0];
  // Open-drain column drives only its low level
  assign pin_oe[15:8] = dir_ff[15:8] & (~col_od | ~data_ff[15:8]);
  assign row_pullup_en = ~dir_ff[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Filter sample tick

  logic tick;

  assign tick = cnt_ff == CNT_LAST;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_ff <= '0;
    end
    else if (tick)
    begin
      cnt_ff <= '0;
    end
    else
    begin
      cnt_ff <= cnt_ff + CW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Press and release chains

  logic press_in;
  logic rel_in;
  logic [STAGES-1:0] nxt_press_ch;
  logic [STAGES-1:0] nxt_rel_ch;
  logic press_set;
  logic rel_set;

  // Sensed level is used, so an output row driven low counts as a press
  assign press_in = |(rows_en & ~sensed[7:0]);
  assign rel_in = &(~rows_en | sensed[7:0]);
  assign nxt_press_ch = {press_ch_ff[STAGES-2:0], press_in};
  assign nxt_rel_ch = {rel_ch_ff[STAGES-2:0], rel_in};

  // Set fires when the chain becomes full at a sample, like a clocked latch
  // set; a software command that loads the chain never raises a flag.
  assign press_set = tick & ~press_sync_clr & (&nxt_press_ch)
    & ~(&press_ch_ff);
  assign rel_set = tick & ~rel_sync_set & (&nxt_rel_ch)
    & ~(&rel_ch_ff);

  // Chains keep their history across a flag clear, so short events can
  // complete a partly filled chain unless software reloads it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      press_ch_ff <= '0;
    end
    else if (press_sync_clr)
    begin
      press_ch_ff <= '0;
    end
    else if (tick)
    begin
      press_ch_ff <= nxt_press_ch;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rel_ch_ff <= '0;
    end
    else if (rel_sync_set)
    begin
      rel_ch_ff <= '1;
    end
    else if (tick)
    begin
      rel_ch_ff <= nxt_rel_ch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags; a set in the clearing cycle wins

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      press_flag_ff <= 1'b0;
    end
    else
    begin
      press_flag_ff <= press_set | (press_flag_ff & ~press_clr);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      release_flag_ff <= 1'b0;
    end
    else
    begin
      release_flag_ff <= rel_set | (release_flag_ff & ~rel_clr);
    end
  end

  assign kp_irq = (press_flag_ff & press_ie_ff)
    | (release_flag_ff & release_ie_ff);

  ////////////////////////////////////////////////////////////////////////////
  // Read data, captured in the setup cycle

  logic [15:0] stat_view;
  logic [15:0] rd_mux;

  always_comb
  begin
    stat_view = '0;
    stat_view[kp_pkg::KP_ST_PRESS] = press_flag_ff;
    stat_view[kp_pkg::KP_ST_RELEASE] = release_flag_ff;
    stat_view[kp_pkg::KP_ST_REL_IE] = release_ie_ff;
    stat_view[kp_pkg::KP_ST_PRESS_IE] = press_ie_ff;
  end

  always_comb
  begin
    rd_mux = '0;
    if (sel_ctrl)
    begin
      rd_mux = ctrl_ff;
    end
    else if (sel_stat)
    begin
      rd_mux = stat_view;
    end
    else if (sel_dir)
    begin
      rd_mux = dir_ff;
    end
    else if (sel_data)
    begin
      rd_mux = sensed;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff <= '0;
    end
    else if (psel & ~penable)
    begin
      prdata_ff <= {16'h0000, rd_mux};
    end
  end

  assign prdata = prdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_press_clr_wr;
    psel & penable & pwrite & sel_stat & pstrb[0]
      & pwdata[kp_pkg::KP_ST_PRESS_CLR];
  endsequence

  sequence s_chain_fills;
    tick & (&nxt_press_ch) & ~(&press_ch_ff) & ~press_sync_clr;
  endsequence

  a_press_sets: assert property (s_chain_fills |=> press_flag_ff)
    else $error("press flag did not set when chain filled");

  a_sync_clear: assert property (s_press_clr_wr |=> press_ch_ff == '0
    ##0 ~press_set)
    else $error("press chain not cleared by command");

  a_press_hold: assert property (press_flag_ff & ~press_clr
    |=> press_flag_ff)
    else $error("press flag dropped without a clear");

  a_rel_zero_keep: assert property (release_flag_ff & stat_wr
    & ~pwdata[kp_pkg::KP_ST_RELEASE] |=> release_flag_ff)
    else $error("writing zero cleared release flag");

  a_rel_clears: assert property (rel_clr & ~rel_set
    |=> ~release_flag_ff)
    else $error("release flag not cleared by one");

  a_irq_gate: assert property (~press_ie_ff & ~release_ie_ff
    |-> ~kp_irq)
    else $error("request raised with both enables low");

  a_irq_press: assert property (press_set & press_ie_ff
    & ~(stat_wr & pstrb[1]) |=> kp_irq)
    else $error("enabled press flag gave no request");

  a_od_no_high: assert property ((pin_oe[15:8] & col_od
    & pin_out[15:8]) == 8'h00)
    else $error("open-drain column driven high");

  a_input_float: assert property ((pin_oe & ~dir_ff) == 16'h0000)
    else $error("input pin is being driven");

  a_cmd_read_zero: assert property (psel & ~penable & ~pwrite & sel_stat
    |=> prdata[kp_pkg::KP_ST_PRESS_CLR] == 1'b0
    && prdata[kp_pkg::KP_ST_REL_SET] == 1'b0)
    else $error("chain command bit read back non-zero");

  a_reset_clear: assert property ($rose(presetn) |-> ctrl_ff == 16'h0000
    && dir_ff == 16'h0000)
    else $error("control or direction not cleared by reset");

endmodule

// File: kp_pkg.sv
package kp_pkg;

  // Register indices; byte address on the bus is four times the index
  localparam logic [31:0] KP_CTRL_IDX = 32'h10003000;
  localparam logic [31:0] KP_STAT_IDX = 32'h10003002;
  localparam logic [31:0] KP_DIR_IDX = 32'h10003004;
  localparam logic [31:0] KP_DATA_IDX = 32'h10003006;

  // Status register fields
  localparam int unsigned KP_ST_PRESS = 0;
  localparam int unsigned KP_ST_RELEASE = 1;
  localparam int unsigned KP_ST_PRESS_CLR = 2;
  localparam int unsigned KP_ST_REL_SET = 3;
  localparam int unsigned KP_ST_REL_IE = 8;
  localparam int unsigned KP_ST_PRESS_IE = 9;

  // Reset values
  localparam logic [15:0] KP_CTRL_RST = 16'h0000;
  localparam logic [15:0] KP_DIR_RST = 16'h0000;

  // Port shape
  localparam int unsigned KP_PINS = 16;
  localparam int unsigned KP_ROWS = 8;
  localparam int unsigned KP_SYNC_STAGES = 4;

  // Timing: 256 Hz filter sample clock derived from the 40 MHz bus clock
  localparam int unsigned KP_CLK_PERIOD_NS = 25;
  localparam int unsigned KP_SAMPLE_PERIOD_NS = 3906250;
  localparam int unsigned KP_FILTER_MS = 16;
  localparam int unsigned KP_SAMPLE_DIV =
    KP_SAMPLE_PERIOD_NS / KP_CLK_PERIOD_NS;

endpackage

// File: kp_keypad_model.sv
`timescale 1ns/1ps
module kp_keypad_model (
  // Clock for the floating-line pattern
  input wire logic pclk,
  // Port side of the block
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  input wire logic [7:0] row_pullup_en,
  output logic [15:0] pin_in,
  // Keys at row*8+col, discrete switches to ground
  input wire logic [63:0] key,
  input wire logic [7:0] sw_gnd
);
  logic tog_ff;
  initial tog_ff = 1'b0;
  // Undriven lines toggle so a stale level is never read as real
  always @(posedge pclk) tog_ff <= ~tog_ff;
  always_comb
  begin
    for (int c = 0; c < 8; c++)
      pin_in[8+c] = pin_oe[8+c] ? pin_out[8+c] : tog_ff;
    for (int r = 0; r < 8; r++)
    begin
      pin_in[r] = pin_oe[r] ? pin_out[r] : row_pullup_en[r] ? 1'b1 : tog_ff;
      for (int c = 0; c < 8; c++)
        if (!pin_oe[r] && key[r*8+c] && pin_oe[8+c] && !pin_out[8+c])
          pin_in[r] = 1'b0;
      if (!pin_oe[r] && sw_gnd[r])
        pin_in[r] = 1'b0;
    end
  end
endmodule

// File: keypad_matrix_port_tb.sv
`timescale 1ns/1ps
module keypad_matrix_port_tb;
  localparam int DIV = 4;
  localparam logic [31:0] A_CTL = kp_pkg::KP_CTRL_IDX << 2;
  localparam logic [31:0] A_ST = kp_pkg::KP_STAT_IDX << 2;
  localparam logic [31:0] A_DIR = kp_pkg::KP_DIR_IDX << 2;
  localparam logic [31:0] A_DAT = kp_pkg::KP_DATA_IDX << 2;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, kp_irq, er;
  logic [31:0] paddr, pwdata, prdata, seed, rd, r;
  logic [3:0] pstrb;
  logic [15:0] pin_in, pin_out, pin_oe, m_ctl, m_dir, m_lat;
  logic [7:0] row_pullup_en, sw_gnd;
  logic [63:0] key;
  logic m_pf, m_rf, m_pie, m_rie, lo, acc, sw, ps, rs;
  int errors, comparisons, cyc, tcnt, pcnt, rcnt;
  kp_matrix_port #(.SAMPLE_DIV(DIV), .STAGES(4)) dut_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .row_pullup_en(row_pullup_en),
    .kp_irq(kp_irq));
  kp_keypad_model part_u (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .row_pullup_en(row_pullup_en), .pin_in(pin_in), .key(key),
    .sw_gnd(sw_gnd));
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  //////////////////////////////////////////////////////////////////////////
  // Reference: bus writes and chains as run lengths of matching ticks.
  // One process, so a command in a tick cycle beats the shift and a set
  // beats a clear in a fixed order, with no race against the bus task.
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      tcnt = 0;
      pcnt = 0;
      rcnt = 0;
      m_pf = 1'b0;
      m_rf = 1'b0;
      m_ctl = 16'h0000;
      m_dir = 16'h0000;
      m_pie = 1'b0;
      m_rie = 1'b0;
    end
    else
    begin
      acc = psel && penable && pwrite && pready;
      sw = acc && paddr == A_ST && pstrb[0];
      ps = 1'b0;
      rs = 1'b0;
      if (tcnt == DIV - 1)
      begin
        tcnt = 0;
        lo = |(~pin_in[7:0] & m_ctl[7:0]);
        ps = lo && pcnt == 3 && !(sw && pwdata[kp_pkg::KP_ST_PRESS_CLR]);
        rs = !lo && rcnt == 3 && !(sw && pwdata[kp_pkg::KP_ST_REL_SET]);
        pcnt = lo ? (pcnt < 4 ? pcnt + 1 : 4) : 0;
        rcnt = !lo ? (rcnt < 4 ? rcnt + 1 : 4) : 0;
      end
      else tcnt++;
      if (acc && paddr == A_CTL) m_ctl = mrg(m_ctl, pwdata[15:0], pstrb);
      if (acc && paddr == A_DIR) m_dir = mrg(m_dir, pwdata[15:0], pstrb);
      if (acc && paddr == A_DAT) m_lat = mrg(m_lat, pwdata[15:0], pstrb);
      if (sw && pwdata[kp_pkg::KP_ST_PRESS]) m_pf = 1'b0;
      if (sw && pwdata[kp_pkg::KP_ST_RELEASE]) m_rf = 1'b0;
      if (sw && pwdata[kp_pkg::KP_ST_PRESS_CLR]) pcnt = 0;
      if (sw && pwdata[kp_pkg::KP_ST_REL_SET]) rcnt = 4;
      if (acc && paddr == A_ST && pstrb[1])
      begin
        m_pie = pwdata[kp_pkg::KP_ST_PRESS_IE];
        m_rie = pwdata[kp_pkg::KP_ST_REL_IE];
      end
      if (ps) m_pf = 1'b1;
      if (rs) m_rf = 1'b1;
    end
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      finish_test;
    end
  end
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function logic [15:0] mrg(logic [15:0] o, logic [15:0] d, logic [3:0] s);
    return {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction
  function logic [31:0] exp_rd(logic [31:0] a);
    logic [31:0] e;
    e = 32'h0;
    if (a == A_CTL) e[15:0] = m_ctl;
    if (a == A_DIR) e[15:0] = m_dir;
    if (a == A_DAT) e[15:0] = (m_lat & m_dir) | (pin_in & ~m_dir);
    if (a == A_ST)
    begin
      e[kp_pkg::KP_ST_PRESS] = m_pf;
      e[kp_pkg::KP_ST_RELEASE] = m_rf;
      e[kp_pkg::KP_ST_REL_IE] = m_rie;
      e[kp_pkg::KP_ST_PRESS_IE] = m_pie;
    end
    return e;
  endfunction
  task chk_reg(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task chk_pins;
    logic [39:0] e;
    // Settled drive after the last write edge
    @(negedge pclk);
    e = {m_dir[15:8] & (~m_ctl[15:8] | ~m_lat[15:8]), m_dir[7:0],
      m_lat & m_dir, ~m_dir[7:0]};
    comparisons++;
    if ({pin_oe, pin_out, row_pullup_en} !== e)
    begin
      errors++;
      $display("[ERR] %0t pin drive mismatch", $time);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  // APB master; zero wait is not assumed, the loop waits for pready
  task apb(input logic [31:0] a, input logic w, input logic [15:0] d,
    input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {16'h0000, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // Only pready or, failing that, the bench timeout ends this wait
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [31:0] a, input logic [15:0] d);
    apb(a, 1'b1, d, 4'h3);
  endtask
  task rchk(input logic [31:0] a);
    apb(a, 1'b0, 16'h0000, 4'h3);
    @(negedge pclk);
    chk_reg(rd, exp_rd(a));
    chk_bit(er, !(a inside {A_CTL, A_ST, A_DIR, A_DAT}));
    chk_bit(kp_irq, (m_pf & m_pie) | (m_rf & m_rie));
  endtask
  task finish_test;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, pstrb, key, sw_gnd} = '0;
    {presetn, errors, comparisons, cyc} = '0;
    seed = 32'h20e2;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rchk(A_CTL);
    rchk(A_DIR);
    chk_pins;
    wr(A_DAT + 32'h4, 16'hffff);
    rchk(A_DAT + 32'h4);
    // Byte and halfword lanes with random drive settings
    repeat (8)
    begin
      r = xs();
      apb(A_DAT, 1'b1, r[15:0], 4'h3);
      apb(A_DIR, 1'b1, r[31:16], {2'b00, r[3:2] | {1'b0, ~|r[3:2]}});
      apb(A_CTL, 1'b1, 16'(xs()), {2'b00, r[5:4] | {1'b0, ~|r[5:4]}});
      chk_pins;
      rchk(A_CTL);
    end
    wr(A_DIR, 16'hfff0);
    repeat (4) @(posedge pclk);
    rchk(A_DAT);
    wr(A_DAT, 16'h0000);
    wr(A_DIR, 16'hff00);
    wr(A_CTL, 16'hff01);
    wr(A_ST, 16'h0207);
    repeat (64) @(posedge pclk);
    rchk(A_ST);
    @(posedge pclk) key[0] <= 1'b1;
    repeat (64) @(posedge pclk);
    rchk(A_ST);
    wr(A_ST, 16'h0200);
    rchk(A_ST);
    wr(A_ST, 16'h0201);
    repeat (64) @(posedge pclk);
    rchk(A_ST);
    wr(A_ST, 16'h0204);
    repeat (64) @(posedge pclk);
    rchk(A_ST);
    wr(A_ST, 16'h0101);
    key[0] <= 1'b0;
    repeat (64) @(posedge pclk);
    rchk(A_ST);
    wr(A_ST, 16'h0100);
    rchk(A_ST);
    wr(A_ST, 16'h010a);
    repeat (64) @(posedge pclk);
    rchk(A_ST);
    @(posedge pclk) sw_gnd[1] <= 1'b1;
    repeat (64) @(posedge pclk);
    rchk(A_ST);
    @(posedge pclk) sw_gnd[1] <= 1'b0;
    wr(A_DIR, 16'hff04);
    wr(A_CTL, 16'hff04);
    wr(A_ST, 16'h0200);
    repeat (64) @(posedge pclk);
    rchk(A_ST);
    chk_pins;
    finish_test;
  end
endmodule
